/* File: logic/rx_packet_filter_dc_free_select_decoder.sv */
// receive packet filter: sync hunt, length/address/crc filtering, dc-free decoding
//
// Behaviour
// - sync hunt uses configured pattern, size, tolerance
// - packets without sync dropped, no interrupt
// - sync found starts payload, raises match flag
// - address checked after sync, shares match flag
// - mode 01: address must equal node identifier
// - mode 10: node or broadcast identifier accepted
// - address byte is written to fifo
// - variable length: length below maximum accepted
// - length byte is written to fifo
// - crc compared with trailing bytes, pass flagged
// - crc fail clears fifo, no interrupt
// - keep bit: fail keeps fifo, interrupt
// - checksum bytes never enter the fifo
// - ccitt checksum catches leading/trailing zeros
// - manchester only for select 01, packet mode
// - chip pair 10 is one, 01 zero
// - manchester halves bit rate, chip rate fixed
// - preamble and sync stay plain nrz
// - select 10 de-whitens payload and checksum
// - first variable byte loads length counter
// - address is byte two variable, one fixed
module rx_packet_filter_dc_free_select_decoder (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic rx_enable_i,
  input wire rx_filter_pkg::rx_cfg_s cfg_i,
  input wire logic chip_i,
  input wire logic chip_valid_i,
  output logic [7:0] fifo_data_o,
  output logic fifo_wr_o,
  output logic fifo_clear_o,
  output logic sync_addr_match_flag_o,
  output logic crc_pass_flag_o,
  output logic payload_avail_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [6:0] sync_errs(input logic [63:0] sh, input logic [63:0] pat,
                                           input logic [2:0] size);
    int nbits;
    logic [6:0] cnt;
    nbits = 8 * (int'(size) + 1);
    cnt = 7'h00;
    for (int i = 0; i < rx_filter_pkg::SYNC_BITS; i++) begin
      if (i < nbits && sh[i] != pat[i + rx_filter_pkg::SYNC_BITS - nbits]) begin
        cnt = cnt + 7'h01;
      end
    end
    return cnt;
  endfunction

  function automatic logic addr_ok(input logic [7:0] b, input rx_filter_pkg::rx_cfg_s c);
    logic ok;
    ok = (b == c.node_identifier);
    if (c.addr_filter_mode == rx_filter_pkg::ADDR_NODE_BCAST) begin
      ok = ok || (b == c.broadcast_identifier);
    end
    return ok;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  localparam logic [7:0] RST_BYTE_C = rx_filter_pkg::RST_BYTE;
  localparam logic [63:0] RST_SHIFT_C = rx_filter_pkg::RST_SHIFT;

  rx_filter_pkg::rx_state_e st_q, st_d;
  logic [63:0] sh_q, sh_d;
  logic [2:0] bitcnt_q, bitcnt_d;
  logic [8:0] idx_q, idx_d;
  logic [7:0] byte_q, byte_d, rem_q, rem_d, crcrx_q, crcrx_d, data_q, data_d;
  logic half_q, half_d, chip1_q, chip1_d, prev_chip_q, prev_chip_d;
  logic wr_q, wr_d, clr_q, clr_d, flag_q, flag_d, pass_q, pass_d, irq_q, irq_d;

  logic [63:0] sh_new;
  logic [15:0] crc_val;
  logic [7:0] nb;
  logic sync_hit, in_pkt, manch, white, bit_v, raw_bit, dec_bit, lfsr_out;
  logic byte_done, is_var, unlimited, len_bad, addr_bad, last_byte, crc_done, crc_good;

  ////////////////////////////////////////////////////////////////////////////
  // bit path

  assign is_var = cfg_i.length_format_sel;
  assign unlimited = !is_var && cfg_i.max_payload_len == RST_BYTE_C;
  assign sh_new = {sh_q[62:0], chip_i};
  assign sync_hit = rx_enable_i && st_q == rx_filter_pkg::ST_HUNT && chip_valid_i &&
    sync_errs(sh_new, cfg_i.sync_pattern_regs, cfg_i.sync_size) <= {4'h0, cfg_i.sync_tol};
  assign in_pkt = st_q != rx_filter_pkg::ST_HUNT;
  assign manch = cfg_i.packet_mode && cfg_i.dc_free_select == rx_filter_pkg::DC_MANCH;
  assign white = cfg_i.dc_free_select == rx_filter_pkg::DC_WHITE;
  // one user bit per chip, or per chip pair under manchester, same chip strobe throughout the packet
  assign bit_v = in_pkt && chip_valid_i && (!manch || half_q);
  // a 10 pair decodes from its first chip; illegal 00/11 pairs also follow the first chip
  assign raw_bit = manch ? chip1_q : chip_i;
  assign dec_bit = raw_bit ^ (white & lfsr_out);
  assign nb = {byte_q[6:0], dec_bit};
  assign byte_done = bit_v && bitcnt_q == rx_filter_pkg::BIT_LAST;

  assign len_bad = is_var && idx_q == rx_filter_pkg::ADDR_IDX_FIX &&
    nb >= cfg_i.max_payload_len;
  assign addr_bad = cfg_i.addr_filter_mode != rx_filter_pkg::ADDR_OFF &&
    idx_q == (is_var ? rx_filter_pkg::ADDR_IDX_VAR : rx_filter_pkg::ADDR_IDX_FIX) &&
    !addr_ok(nb, cfg_i);
  assign last_byte = (is_var && idx_q == rx_filter_pkg::ADDR_IDX_FIX) ? nb == RST_BYTE_C :
    (rem_q == 8'h01 && !unlimited);
  assign crc_done = st_q == rx_filter_pkg::ST_CHECK && byte_done && idx_q[0];
  assign crc_good = {crcrx_q, nb} == crc_val;

  crc_ccitt_serial u_crc (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .init_i(sync_hit),
    .step_i(bit_v && st_q == rx_filter_pkg::ST_PAYLOAD),
    .bit_i(dec_bit),
    .crc_o(crc_val)
  );

  dewhite_lfsr u_lfsr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .seed_i(sync_hit),
    .step_i(bit_v && white),
    .out_o(lfsr_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // packet sequencer

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    half_d = half_q;
    chip1_d = chip1_q;
    byte_d = byte_q;
    bitcnt_d = bitcnt_q;
    idx_d = idx_q;
    rem_d = rem_q;
    crcrx_d = crcrx_q;
    data_d = data_q;
    wr_d = 1'b0;
    clr_d = 1'b0;
    flag_d = flag_q;
    pass_d = pass_q;
    irq_d = 1'b0;
    prev_chip_d = chip_valid_i ? chip_i : prev_chip_q;
    if (chip_valid_i && !in_pkt) begin
      sh_d = sh_new;
    end
    if (chip_valid_i && in_pkt && manch) begin
      half_d = !half_q;
      if (!half_q) begin
        chip1_d = chip_i;
      end
    end
    if (bit_v) begin
      byte_d = nb;
      bitcnt_d = bitcnt_q + 3'h1;
    end
    unique case (st_q)
      rx_filter_pkg::ST_HUNT: begin
        if (sync_hit) begin
          st_d = rx_filter_pkg::ST_PAYLOAD;
          flag_d = 1'b1;
          sh_d = RST_SHIFT_C;
          half_d = 1'b0;
          bitcnt_d = 3'h0;
          idx_d = 9'h000;
          rem_d = cfg_i.max_payload_len;
        end
      end
      rx_filter_pkg::ST_PAYLOAD: begin
        if (byte_done) begin
          idx_d = idx_q + 9'h001;
          if (len_bad || addr_bad) begin
            // the length byte may already sit in the fifo, so the discard flushes it
            clr_d = 1'b1;
            flag_d = 1'b0;
            st_d = rx_filter_pkg::ST_HUNT;
          end else begin
            wr_d = 1'b1;
            data_d = nb;
            if (is_var && idx_q == rx_filter_pkg::ADDR_IDX_FIX) begin
              rem_d = nb;
            end else begin
              rem_d = rem_q - 8'h01;
            end
            if (last_byte) begin
              idx_d = 9'h000;
              if (cfg_i.crc_check_enable) begin
                st_d = rx_filter_pkg::ST_CHECK;
              end else begin
                irq_d = 1'b1;
                flag_d = 1'b0;
                st_d = rx_filter_pkg::ST_HUNT;
              end
            end
          end
        end
      end
      rx_filter_pkg::ST_CHECK: begin
        if (byte_done) begin
          idx_d = idx_q + 9'h001;
          crcrx_d = nb;
        end
        if (crc_done) begin
          pass_d = crc_good;
          irq_d = crc_good || cfg_i.keep_on_crc_fail;
          clr_d = !crc_good && !cfg_i.keep_on_crc_fail;
          flag_d = 1'b0;
          st_d = rx_filter_pkg::ST_HUNT;
        end
      end
      default: begin
        st_d = rx_filter_pkg::ST_HUNT;
      end
    endcase
    if (!rx_enable_i) begin
      st_d = rx_filter_pkg::ST_HUNT;
      flag_d = 1'b0;
      irq_d = 1'b0;
      wr_d = 1'b0;
      clr_d = 1'b0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      st_q <= rx_filter_pkg::ST_HUNT;
      sh_q <= RST_SHIFT_C;
      half_q <= 1'b0;
      chip1_q <= 1'b0;
      byte_q <= RST_BYTE_C;
      bitcnt_q <= 3'h0;
      idx_q <= 9'h000;
      rem_q <= RST_BYTE_C;
      crcrx_q <= RST_BYTE_C;
      data_q <= RST_BYTE_C;
      wr_q <= 1'b0;
      clr_q <= 1'b0;
      flag_q <= 1'b0;
      pass_q <= 1'b0;
      irq_q <= 1'b0;
      prev_chip_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      half_q <= half_d;
      chip1_q <= chip1_d;
      byte_q <= byte_d;
      bitcnt_q <= bitcnt_d;
      idx_q <= idx_d;
      rem_q <= rem_d;
      crcrx_q <= crcrx_d;
      data_q <= data_d;
      wr_q <= wr_d;
      clr_q <= clr_d;
      flag_q <= flag_d;
      pass_q <= pass_d;
      irq_q <= irq_d;
      prev_chip_q <= prev_chip_d;
    end
  end

  assign fifo_data_o = data_q;
  assign fifo_wr_o = wr_q;
  assign fifo_clear_o = clr_q;
  assign sync_addr_match_flag_o = flag_q;
  assign crc_pass_flag_o = pass_q;
  assign payload_avail_irq_o = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence s_sync_seen;
    sync_hit;
  endsequence
  sequence s_payload_open;
    flag_q && st_q == rx_filter_pkg::ST_PAYLOAD;
  endsequence
  property p_sync_start;
    s_sync_seen |=> s_payload_open;
  endproperty
  a_sync_start: assert property (p_sync_start) else $error("sync seen but no payload");
  property p_irq_needs_packet;
    payload_avail_irq_o |-> $past(st_q) != rx_filter_pkg::ST_HUNT;
  endproperty
  a_irq_needs_packet: assert property (p_irq_needs_packet) else $error("irq without packet");
  property p_len_reject;
    st_q == rx_filter_pkg::ST_PAYLOAD && byte_done && len_bad && rx_enable_i
      |=> fifo_clear_o && !fifo_wr_o && st_q == rx_filter_pkg::ST_HUNT;
  endproperty
  a_len_reject: assert property (p_len_reject) else $error("long packet kept");
  property p_addr_reject;
    st_q == rx_filter_pkg::ST_PAYLOAD && byte_done && addr_bad && rx_enable_i
      |=> fifo_clear_o && !sync_addr_match_flag_o;
  endproperty
  a_addr_reject: assert property (p_addr_reject) else $error("foreign address kept");
  property p_crc_fail_clear;
    crc_done && !crc_good && !cfg_i.keep_on_crc_fail && rx_enable_i
      |=> fifo_clear_o && !payload_avail_irq_o && !crc_pass_flag_o;
  endproperty
  a_crc_fail_clear: assert property (p_crc_fail_clear) else $error("crc fail not flushed");
  property p_crc_fail_keep;
    crc_done && !crc_good && cfg_i.keep_on_crc_fail && rx_enable_i
      |=> payload_avail_irq_o && !fifo_clear_o;
  endproperty
  a_crc_fail_keep: assert property (p_crc_fail_keep) else $error("kept packet no irq");
  property p_no_crc_in_fifo;
    st_q == rx_filter_pkg::ST_CHECK |=> !fifo_wr_o;
  endproperty
  a_no_crc_in_fifo: assert property (p_no_crc_in_fifo) else $error("checksum in fifo");
  property p_byte_written;
    st_q == rx_filter_pkg::ST_PAYLOAD && byte_done && !len_bad && !addr_bad && rx_enable_i
      |=> fifo_wr_o && fifo_data_o == $past(nb);
  endproperty
  a_byte_written: assert property (p_byte_written) else $error("payload byte lost");
  // chips may be spaced apart, so the pair's first chip is the last strobed one
  property p_manch_pair;
    bit_v && manch && !white |-> half_q && dec_bit == prev_chip_q;
  endproperty
  a_manch_pair: assert property (p_manch_pair) else $error("bad chip pairing");

endmodule

/* File: logic/rx_filter_pkg.sv */
// shared constants, states and carrier types of the receive packet filter
package rx_filter_pkg;

  localparam logic [1:0] ADDR_OFF = 2'h0;
  localparam logic [1:0] ADDR_NODE = 2'h1;
  localparam logic [1:0] ADDR_NODE_BCAST = 2'h2;

  localparam logic [1:0] DC_NONE = 2'h0;
  localparam logic [1:0] DC_MANCH = 2'h1;
  localparam logic [1:0] DC_WHITE = 2'h2;

  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [8:0] LFSR_SEED = 9'h1FF;
  localparam int LFSR_TAP = 5;

  localparam int SYNC_BITS = 64;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [8:0] ADDR_IDX_VAR = 9'h001;
  localparam logic [8:0] ADDR_IDX_FIX = 9'h000;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [63:0] RST_SHIFT = 64'h0000_0000_0000_0000;

  typedef enum logic [1:0] {
    ST_HUNT = 2'b00,
    ST_PAYLOAD = 2'b01,
    ST_CHECK = 2'b11
  } rx_state_e;

  typedef struct packed {
    logic packet_mode;
    logic [63:0] sync_pattern_regs;
    logic [2:0] sync_size;
    logic [2:0] sync_tol;
    logic length_format_sel;
    logic [7:0] max_payload_len;
    logic [1:0] addr_filter_mode;
    logic [7:0] node_identifier;
    logic [7:0] broadcast_identifier;
    logic crc_check_enable;
    logic keep_on_crc_fail;
    logic [1:0] dc_free_select;
  } rx_cfg_s;

endpackage

/* File: logic/crc_ccitt_serial.sv */
// bit-serial ccitt checksum engine, msb first
module crc_ccitt_serial (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic init_i,
  input wire logic step_i,
  input wire logic bit_i,
  output logic [15:0] crc_o
);

  logic [15:0] crc_q;
  logic [15:0] crc_d;
  logic fb;

  always_comb begin
    fb = crc_q[15] ^ bit_i;
    crc_d = crc_q;
    if (init_i) begin
      crc_d = rx_filter_pkg::CRC_INIT;
    end else if (step_i) begin
      crc_d = {crc_q[14:0], 1'b0} ^ (fb ? rx_filter_pkg::CRC_POLY : 16'h0000);
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      crc_q <= rx_filter_pkg::CRC_INIT;
    end else begin
      crc_q <= crc_d;
    end
  end

  // inverted result: a run of leading or trailing zeros no longer leaves it unchanged
  assign crc_o = ~crc_q;

endmodule

/* File: logic/dewhite_lfsr.sv */
// 9-bit de-whitening sequence generator, x^9+x^5+1
module dewhite_lfsr (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic seed_i,
  input wire logic step_i,
  output logic out_o
);

  logic [8:0] lfsr_q;
  logic [8:0] lfsr_d;

  always_comb begin
    lfsr_d = lfsr_q;
    if (seed_i) begin
      lfsr_d = rx_filter_pkg::LFSR_SEED;
    end else if (step_i) begin
      lfsr_d = {lfsr_q[0] ^ lfsr_q[rx_filter_pkg::LFSR_TAP], lfsr_q[8:1]};
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      lfsr_q <= rx_filter_pkg::LFSR_SEED;
    end else begin
      lfsr_q <= lfsr_d;
    end
  end

  assign out_o = lfsr_q[0];

endmodule

/* File: verification/far_end.sv */
// far-end model: demodulated chip source and the receive fifo that the filter feeds
module far_end (
  input wire logic mclk_i,
  output logic chip_o,
  output logic chip_valid_o,
  input wire logic [7:0] fifo_data_i,
  input wire logic fifo_wr_i,
  input wire logic fifo_clear_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] fifo_q[$];
  initial begin
    chip_o = 1'b0;
    chip_valid_o = 1'b0;
  end
  // entered at a falling edge; gap 0 keeps the strobe up for back-to-back chips
  task automatic send_chip(input logic c, input int gap);
    chip_o = c;
    chip_valid_o = 1'b1;
    @(negedge mclk_i);
    if (gap > 0) begin
      chip_valid_o = 1'b0;
      chip_o = ~c;
      repeat (gap) @(negedge mclk_i);
    end
  endtask
  // a stale chip must not look valid, so the line shows the inverse once released
  task automatic idle();
    chip_valid_o = 1'b0;
    chip_o = ~chip_o;
  endtask
  ////////////////////////////////////////////////////////////////
  always @(posedge mclk_i) begin
    if (fifo_clear_i === 1'b1) fifo_q.delete();
    else if (fifo_wr_i === 1'b1) fifo_q.push_back(fifo_data_i);
  end
endmodule

/* File: verification/tb_top.sv */
// self-checking bench: packets built from a queue model, compared with the fifo contents
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic rx_enable_i = 1'b0;
  rx_filter_pkg::rx_cfg_s cfg_i;
  logic chip_i;
  logic chip_valid_i;
  logic [7:0] fifo_data_o;
  logic fifo_wr_o;
  logic fifo_clear_o;
  logic sync_addr_match_flag_o;
  logic crc_pass_flag_o;
  logic payload_avail_irq_o;
  logic flag_seen = 1'b0;
  logic [31:0] rng = 32'h0000_5735;
  int n_fail = 0;
  int tests_run = 0;
  int n_irq = 0;

  always #20 mclk_i = ~mclk_i;

  rx_packet_filter_dc_free_select_decoder rx_packet_filter_dc_free_select_decoder_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .rx_enable_i(rx_enable_i), .cfg_i(cfg_i),
    .chip_i(chip_i), .chip_valid_i(chip_valid_i), .fifo_data_o(fifo_data_o),
    .fifo_wr_o(fifo_wr_o), .fifo_clear_o(fifo_clear_o),
    .sync_addr_match_flag_o(sync_addr_match_flag_o), .crc_pass_flag_o(crc_pass_flag_o),
    .payload_avail_irq_o(payload_avail_irq_o)
  );
  far_end far_end_inst (
    .mclk_i(mclk_i), .chip_o(chip_i), .chip_valid_o(chip_valid_i), .fifo_data_i(fifo_data_o),
    .fifo_wr_i(fifo_wr_o), .fifo_clear_i(fifo_clear_o)
  );

  always @(posedge mclk_i) begin
    if (payload_avail_irq_o === 1'b1) n_irq++;
    if (sync_addr_match_flag_o === 1'b1) flag_seen = 1'b1;
  end

  ////////////////////////////////////////////////////////////////
  // xorshift, seeded at 22325
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic setc(input logic fmt, input logic [1:0] mode, input logic crc,
                      input logic keep, input logic [1:0] dc, input logic pm);
    cfg_i.length_format_sel = fmt;
    cfg_i.addr_filter_mode = mode;
    cfg_i.crc_check_enable = crc;
    cfg_i.keep_on_crc_fail = keep;
    cfg_i.dc_free_select = dc;
    cfg_i.packet_mode = pm;
    cfg_i.max_payload_len = 8'h40;
  endtask

  ////////////////////////////////////////////////////////////////
  // one packet: n bytes after the optional length byte, serr flipped sync chips
  task automatic pkt(input int n, input int lenb, input int addr, input int serr,
                     input logic bad);
    logic [7:0] body[$];
    logic [7:0] exp_q[$];
    logic dbits[$];
    logic bits[$];
    logic [15:0] crc;
    logic [8:0] lf;
    logic ok;
    logic hit;
    logic b;
    int idx;
    crc = 16'hFFFF;
    lf = 9'h1FF;
    idx = cfg_i.length_format_sel ? 1 : 0;
    if (cfg_i.length_format_sel) body.push_back(lenb[7:0]);
    else cfg_i.max_payload_len = n[7:0];
    repeat (n) body.push_back(8'(xs()));
    if (addr >= 0) body[idx] = addr[7:0];
    hit = rx_enable_i && serr <= int'(cfg_i.sync_tol);
    ok = hit;
    if (cfg_i.length_format_sel && body[0] >= cfg_i.max_payload_len) ok = 1'b0;
    if (cfg_i.addr_filter_mode != rx_filter_pkg::ADDR_OFF
        && body[idx] != cfg_i.node_identifier
        && !(cfg_i.addr_filter_mode == rx_filter_pkg::ADDR_NODE_BCAST
             && body[idx] == cfg_i.broadcast_identifier)) ok = 1'b0;
    for (int i = 0; i < 8 * (int'(cfg_i.sync_size) + 1); i++) begin
      bits.push_back(cfg_i.sync_pattern_regs[63 - i] ^ (i < serr));
    end
    foreach (body[k]) begin
      for (int i = 7; i >= 0; i--) begin
        dbits.push_back(body[k][i]);
        crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ body[k][i]) ? 16'h1021 : 16'h0000);
      end
    end
    crc = ~crc ^ {15'h0000, bad};
    if (cfg_i.crc_check_enable) begin
      for (int i = 15; i >= 0; i--) dbits.push_back(crc[i]);
    end
    foreach (dbits[k]) begin
      b = dbits[k] ^ (cfg_i.dc_free_select == rx_filter_pkg::DC_WHITE && lf[0]);
      lf = {lf[0] ^ lf[5], lf[8:1]};
      bits.push_back(b);
      if (cfg_i.dc_free_select == rx_filter_pkg::DC_MANCH && cfg_i.packet_mode) begin
        bits.push_back(~b);
      end
    end
    n_irq = 0;
    flag_seen = 1'b0;
    far_end_inst.fifo_q.delete();
    repeat (8) far_end_inst.send_chip(1'b0, 0);
    foreach (bits[k]) far_end_inst.send_chip(bits[k], int'(xs() % 3));
    far_end_inst.idle();
    repeat (30) @(negedge mclk_i);
    if (ok && (!cfg_i.crc_check_enable || !bad || cfg_i.keep_on_crc_fail)) exp_q = body;
    check("match flag seen", 32'(hit), 32'(flag_seen));
    check("match flag after packet", 32'h0, 32'(sync_addr_match_flag_o));
    check("payload irq count", 32'(exp_q.size() > 0), 32'(n_irq));
    if (ok && cfg_i.crc_check_enable) begin
      check("crc pass flag", 32'(!bad), 32'(crc_pass_flag_o));
    end
    check("fifo byte count", 32'(exp_q.size()), 32'(far_end_inst.fifo_q.size()));
    foreach (exp_q[k]) begin
      if (k < far_end_inst.fifo_q.size()) begin
        check("fifo byte", 32'(exp_q[k]), 32'(far_end_inst.fifo_q[k]));
      end
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    int m;
    cfg_i = '0;
    cfg_i.sync_pattern_regs = 64'h2DD4_93C6_A55A_0FF0;
    cfg_i.sync_size = 3'h3;
    cfg_i.sync_tol = 3'h1;
    cfg_i.node_identifier = 8'h42;
    cfg_i.broadcast_identifier = 8'hFF;
    repeat (8) @(negedge mclk_i);
    check("outputs in reset", 32'h0, 32'({fifo_wr_o, fifo_clear_o, sync_addr_match_flag_o,
                                          crc_pass_flag_o, payload_avail_irq_o}));
    rst_i = 1'b0;
    rx_enable_i = 1'b1;
    setc(1'b0, rx_filter_pkg::ADDR_OFF, 1'b0, 1'b0, rx_filter_pkg::DC_NONE, 1'b1);
    pkt(5, 0, -1, 0, 1'b0);
    pkt(3, 0, -1, 1, 1'b0);
    // shorter sync right after an accepted packet, so the hunt window starts from zeros
    cfg_i.sync_size = 3'h1;
    pkt(4, 0, -1, 0, 1'b0);
    cfg_i.sync_size = 3'h3;
    pkt(3, 0, -1, 2, 1'b0);
    cfg_i.sync_tol = 3'h0;
    pkt(3, 0, -1, 1, 1'b0);
    cfg_i.sync_tol = 3'h1;
    setc(1'b1, rx_filter_pkg::ADDR_OFF, 1'b1, 1'b0, rx_filter_pkg::DC_WHITE, 1'b1);
    pkt(6, 6, -1, 0, 1'b0);
    pkt(6, 6, -1, 0, 1'b1);
    cfg_i.keep_on_crc_fail = 1'b1;
    pkt(6, 6, -1, 0, 1'b1);
    setc(1'b1, rx_filter_pkg::ADDR_OFF, 1'b1, 1'b0, rx_filter_pkg::DC_MANCH, 1'b1);
    pkt(4, 4, -1, 0, 1'b0);
    cfg_i.packet_mode = 1'b0;
    pkt(4, 4, -1, 0, 1'b0);
    setc(1'b0, rx_filter_pkg::ADDR_NODE, 1'b1, 1'b0, rx_filter_pkg::DC_NONE, 1'b1);
    pkt(4, 0, 8'h42, 0, 1'b0);
    pkt(4, 0, 8'hFF, 0, 1'b0);
    // code 11 behaves as node-only filtering
    cfg_i.addr_filter_mode = 2'h3;
    pkt(4, 0, 8'h42, 0, 1'b0);
    pkt(4, 0, 8'hFF, 0, 1'b0);
    setc(1'b1, rx_filter_pkg::ADDR_NODE_BCAST, 1'b1, 1'b0, rx_filter_pkg::DC_NONE, 1'b1);
    pkt(5, 5, 8'hFF, 0, 1'b0);
    pkt(5, 5, 8'h42, 0, 1'b0);
    pkt(5, 5, 8'h43, 0, 1'b0);
    setc(1'b1, rx_filter_pkg::ADDR_OFF, 1'b0, 1'b0, rx_filter_pkg::DC_NONE, 1'b1);
    cfg_i.max_payload_len = 8'h0A;
    pkt(9, 9, -1, 0, 1'b0);
    pkt(10, 10, -1, 0, 1'b0);
    cfg_i.max_payload_len = 8'hFF;
    pkt(254, 254, -1, 0, 1'b0);
    rx_enable_i = 1'b0;
    pkt(3, 3, -1, 0, 1'b0);
    rx_enable_i = 1'b1;
    for (int r = 0; r < 8; r++) begin
      m = 1 + int'(xs() % 12);
      setc(1'(xs()), rx_filter_pkg::ADDR_OFF, 1'(xs()), 1'(xs()), 2'(xs() % 3), 1'b1);
      pkt(m, m, -1, 0, 1'(xs()));
    end
    give_verdict();
  end

  // the traffic above needs some 11000 cycles; beyond 60000 the run has hung
  initial begin
    repeat (60000) @(posedge mclk_i);
    n_fail++;
    give_verdict();
  end
endmodule
